// *** acr_pkg.sv ***
// constants shared by both ends of the configuration register link
// ----------------------------------------------------------------
// Summary of operation
// RULE1: chip-select high disables port, straps control; code gives the straps control only while select has stayed high since reset
// RULE2: strap levels choose stabilizer and output format
// RULE3: output-enable strap high floats data outputs
// RULE4: power-down strap high powers the chip down
// RULE5: four address groups decoded as mapped
// RULE6: reference select resets to C0
// RULE7: host writes zeros into unused bits
// RULE8: host never writes fully unused addresses
// RULE9: reset loads defaults into all registers
// RULE10: 08..18 writes stay shadowed until commit
// RULE11: commit copies all shadows, bit self-clears
// RULE12: local registers duplicated, steered by channel select
// RULE13: both channel bits set write both copies
// RULE14: read with both bits returns channel A
// RULE15: global registers shared, channel bits ignored
// RULE16: sixteen-bit instruction then eight-bit data words
// RULE17: first bit is read; pin turns around
// RULE18: msb first after reset, lsb selectable
// RULE19: shadow reads return last written value
// ----------------------------------------------------------------
package acr_pkg;
  localparam int ADDR_W = 13;
  localparam logic [12:0] A_PORT_CFG = 13'h0000;
  localparam logic [12:0] A_CHIP_ID = 13'h0001;
  localparam logic [12:0] A_CHIP_GRADE = 13'h0002;
  localparam logic [12:0] A_CHANNEL_SELECT = 13'h0005;
  localparam logic [12:0] A_SHADOW_COMMIT = 13'h00FF;
  localparam logic [12:0] A_SHADOW_FIRST = 13'h0008;
  localparam logic [12:0] A_SHADOW_LAST = 13'h0018;
  localparam logic [12:0] A_CONV_FIRST = 13'h0019;
  localparam logic [12:0] A_CONV_LAST = 13'h0025;
  localparam logic [12:0] A_FEAT_FIRST = 13'h0100;
  localparam logic [12:0] A_FEAT_LAST = 13'h011B;
  localparam logic [12:0] A_POWER_MODES = 13'h0008;
  localparam logic [12:0] A_GLOBAL_CLOCK = 13'h0009;
  localparam logic [12:0] A_OFFSET_ADJ = 13'h0010;
  localparam logic [12:0] A_OUTPUT_MODE = 13'h0014;
  localparam logic [12:0] A_REFERENCE_SELECT = 13'h0018;
  localparam int SHADOW_N = 17;
  localparam int CONV_N = 13;
  localparam int MISC_N = 41;
  localparam logic [4:0] IDX_POWER_MODES = 5'h00;
  localparam logic [4:0] IDX_GLOBAL_CLOCK = 5'h01;
  localparam logic [4:0] IDX_OUTPUT_MODE = 5'h0C;
  localparam logic [4:0] IDX_REFERENCE_SELECT = 5'h10;
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_CHANNEL_SELECT = 8'h03;
  localparam logic [7:0] RST_GLOBAL_CLOCK = 8'h01;
  localparam logic [7:0] RST_REFERENCE_SELECT = 8'hC0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // arbitrary identification value, names no real part
  localparam logic [7:0] CHIP_ID_DEFAULT = 8'h5A;
  localparam int PC_LSB_HI = 6;
  localparam int PC_LSB_LO = 1;
  localparam int PC_SRST_HI = 5;
  localparam int PC_SRST_LO = 2;
  localparam int COMMIT_BIT = 0;
  localparam int CH_A_BIT = 0;
  localparam int CH_B_BIT = 1;
  localparam int GC_STABILIZER_BIT = 0;
  localparam int OM_TWOS_BIT = 0;
  localparam int OM_DISABLE_BIT = 4;
  localparam int INSTR_RW_BIT = 15;
  localparam int INSTR_W_HI = 14;
  localparam int INSTR_W_LO = 13;
  localparam int INSTR_BITS = 16;
  localparam int WORD_BITS = 8;
  localparam int FRAME_BITS = 24;
  localparam logic [31:0] H_CTRL = 32'h0000_0000;
  localparam logic [31:0] H_ADDR = 32'h0000_0004;
  localparam logic [31:0] H_WDATA = 32'h0000_0008;
  localparam logic [31:0] H_RDATA = 32'h0000_000C;
  localparam logic [31:0] H_STATUS = 32'h0000_0010;
  localparam int HC_START = 0;
  localparam int HC_READ = 1;
  localparam int HC_LSB = 2;
  localparam int REF_CLK_NS = 5;
  localparam int SCLK_HALF_NS = 60;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS;
endpackage : acr_pkg

// *** acr_link_if.sv ***
// three-wire serial link between the host end and the device end
`timescale 1ns/10ps
`default_nettype none
interface acr_link_if;
  logic serial_clock_or_format_strap;
  logic port_select_n;
  logic host_io_out;
  logic host_io_oe;
  logic dev_io_out;
  logic dev_io_oe;
  logic serial_io_or_stabilizer_strap;
  // pulled high when nobody drives, like a strap to the supply
  assign serial_io_or_stabilizer_strap = dev_io_oe ? dev_io_out : (host_io_oe ? host_io_out : 1'b1);
  modport host (output serial_clock_or_format_strap, output port_select_n, output host_io_out,
                output host_io_oe, input serial_io_or_stabilizer_strap);
  modport device (input serial_clock_or_format_strap, input port_select_n, output dev_io_out,
                  output dev_io_oe, input serial_io_or_stabilizer_strap);
endinterface : acr_link_if
`default_nettype wire

// *** acr_device.sv ***
// device end: serial register bank with shadowing, channel copies and strap fallback
`timescale 1ns/10ps
`default_nettype none
module acr_device #(
  parameter logic [7:0] CHIP_ID = acr_pkg::CHIP_ID_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  acr_link_if.device LINK,
  input wire logic MONITOR_OUT_OR_OUTPUT_ENABLE_STRAP,
  input wire logic MONITOR_CLOCK_OR_POWERDOWN_STRAP,
  output logic DUTY_CYCLE_STABILIZER,
  output logic OUTPUT_FORMAT_SELECT,
  output logic OUTPUT_ENABLE_N,
  output logic POWER_DOWN,
  output logic STRAP_MODE,
  output logic [7:0] REFERENCE_SELECT
);
  import acr_pkg::*;

  // ----------------------------------------------------------------
  // address decoding
  // ----------------------------------------------------------------
  function automatic logic is_shadow(input logic [12:0] a);
    return (a >= A_SHADOW_FIRST) && (a <= A_SHADOW_LAST);
  endfunction : is_shadow

  function automatic logic is_misc(input logic [12:0] a);
    return ((a >= A_CONV_FIRST) && (a <= A_CONV_LAST)) || ((a >= A_FEAT_FIRST) && (a <= A_FEAT_LAST));
  endfunction : is_misc

  function automatic logic [5:0] misc_idx(input logic [12:0] a);
    logic [12:0] d;
    d = (a >= A_FEAT_FIRST) ? (a - A_FEAT_FIRST + 13'(CONV_N)) : (a - A_CONV_FIRST);
    return d[5:0];
  endfunction : misc_idx

  // power modes and offset adjust have one copy per channel
  function automatic logic is_local(input logic [12:0] a);
    return (a == A_POWER_MODES) || (a == A_OFFSET_ADJ);
  endfunction : is_local

  function automatic logic [7:0] shadow_default(input int i);
    if (i == int'(IDX_GLOBAL_CLOCK)) begin
      return RST_GLOBAL_CLOCK;
    end
    if (i == int'(IDX_REFERENCE_SELECT)) begin
      return RST_REFERENCE_SELECT;
    end
    return RST_ZERO;
  endfunction : shadow_default

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : rev16

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : rev8

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic sclk_prev;
  wire logic [4:0] pin_raw = {MONITOR_CLOCK_OR_POWERDOWN_STRAP, MONITOR_OUT_OR_OUTPUT_ENABLE_STRAP,
                              LINK.serial_io_or_stabilizer_strap, LINK.port_select_n,
                              LINK.serial_clock_or_format_strap};

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // idle pin levels (select high, data pulled up, clock and straps low):
      // no false strap level or clock edge follows reset
      pin_meta <= 5'h06;
      pin_sync <= 5'h06;
      sclk_prev <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      sclk_prev <= pin_sync[0];
    end
  end

  wire logic sclk_s = pin_sync[0];
  wire logic cs_n_s = pin_sync[1];
  wire logic sdio_s = pin_sync[2];
  wire logic oe_strap_s = pin_sync[3];
  wire logic pd_strap_s = pin_sync[4];
  wire logic sclk_rise = sclk_s & ~sclk_prev & ~cs_n_s;
  wire logic sclk_fall = ~sclk_s & sclk_prev & ~cs_n_s;

  // ----------------------------------------------------------------
  // register storage and frame state
  // ----------------------------------------------------------------
  logic [7:0] shadow_a [SHADOW_N];
  logic [7:0] shadow_b [SHADOW_N];
  logic [7:0] active_a [SHADOW_N];
  logic [7:0] active_b [SHADOW_N];
  logic [7:0] misc [MISC_N];
  logic [1:0] channel_select;
  logic lsb_first;
  logic strap_mode;
  logic [14:0] shifter;
  logic [3:0] unit_bits;
  logic in_data;
  logic read_frame;
  logic [1:0] word_len;
  logic [2:0] words_done;
  logic [12:0] cur_addr;
  logic [7:0] tx_byte;

  // ----------------------------------------------------------------
  // decode of the shifted bits and the addresses in play
  // ----------------------------------------------------------------
  wire logic [15:0] instr_raw = {shifter, sdio_s};
  wire logic [15:0] instr = lsb_first ? rev16(instr_raw) : instr_raw; // RULE18
  wire logic [7:0] data_raw = {shifter[6:0], sdio_s};
  wire logic [7:0] data_in = lsb_first ? rev8(data_raw) : data_raw; // RULE18
  wire logic [12:0] step_addr = lsb_first ? (cur_addr + 13'h0001) : (cur_addr - 13'h0001);
  wire logic [12:0] rd_addr = in_data ? step_addr : instr[12:0];
  wire logic [4:0] rd_sidx = 5'(rd_addr - A_SHADOW_FIRST);
  wire logic [4:0] wr_sidx = 5'(cur_addr - A_SHADOW_FIRST);
  wire logic [7:0] port_cfg_rd = {1'b0, lsb_first, 3'b011, 1'b0, lsb_first, 1'b0};
  // a read with both channel bits set falls to channel A
  wire logic rd_chan_b = is_local(rd_addr) && (channel_select == 2'b10); // RULE14 RULE15
  wire logic [7:0] shadow_rd = rd_chan_b ? shadow_b[rd_sidx] : shadow_a[rd_sidx]; // RULE19
  wire logic [7:0] rd_byte = is_shadow(rd_addr) ? shadow_rd : // RULE5
                             is_misc(rd_addr) ? misc[misc_idx(rd_addr)] :
                             (rd_addr == A_PORT_CFG) ? port_cfg_rd :
                             (rd_addr == A_CHIP_ID) ? CHIP_ID :
                             (rd_addr == A_CHANNEL_SELECT) ? {6'h00, channel_select} : RST_ZERO;
  wire logic word_ok = (word_len == 2'b11) || (words_done <= {1'b0, word_len}); // RULE16
  wire logic byte_done = sclk_rise && in_data && (unit_bits == 4'(WORD_BITS - 1));
  wire logic wr_now = byte_done && !read_frame && word_ok;
  wire logic wr_shadow = wr_now && is_shadow(cur_addr);
  wire logic wr_a = wr_shadow && (channel_select[CH_A_BIT] || !is_local(cur_addr)); // RULE12 RULE15
  wire logic wr_b = wr_shadow && channel_select[CH_B_BIT] && is_local(cur_addr); // RULE12 RULE13
  wire logic do_commit = wr_now && (cur_addr == A_SHADOW_COMMIT) && data_in[COMMIT_BIT];
  wire logic soft_reset = wr_now && (cur_addr == A_PORT_CFG) && (data_in[PC_SRST_HI] | data_in[PC_SRST_LO]);

  // ----------------------------------------------------------------
  // serial frame engine
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      shifter <= '0;
      unit_bits <= 4'h0;
      in_data <= 1'b0;
      read_frame <= 1'b0;
      word_len <= 2'b00;
      words_done <= 3'h0;
      cur_addr <= '0;
      tx_byte <= RST_ZERO;
      LINK.dev_io_out <= 1'b0;
      LINK.dev_io_oe <= 1'b0;
    end else if (cs_n_s) begin
      unit_bits <= 4'h0;
      in_data <= 1'b0;
      words_done <= 3'h0;
      LINK.dev_io_oe <= 1'b0;
    end else if (sclk_rise) begin
      shifter <= instr_raw[14:0];
      if (!in_data && (unit_bits == 4'(INSTR_BITS - 1))) begin
        in_data <= 1'b1; // RULE16
        unit_bits <= 4'h0;
        read_frame <= instr[INSTR_RW_BIT]; // RULE17
        word_len <= instr[INSTR_W_HI:INSTR_W_LO];
        cur_addr <= instr[12:0];
        tx_byte <= rd_byte;
      end else if (byte_done) begin
        unit_bits <= 4'h0;
        words_done <= (words_done == 3'h4) ? words_done : words_done + 3'h1;
        cur_addr <= step_addr;
        tx_byte <= rd_byte;
      end else begin
        unit_bits <= unit_bits + 4'h1;
      end
    end else if (sclk_fall && in_data && read_frame && word_ok) begin
      // turn the pin around only once data begins
      LINK.dev_io_oe <= 1'b1; // RULE17
      LINK.dev_io_out <= lsb_first ? tx_byte[unit_bits[2:0]] : tx_byte[3'h7 - unit_bits[2:0]]; // RULE18
    end
  end

  // ----------------------------------------------------------------
  // register writes, commit and defaults
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < SHADOW_N; i++) begin
        shadow_a[i] <= shadow_default(i); // RULE6 RULE9
        shadow_b[i] <= shadow_default(i);
        active_a[i] <= shadow_default(i);
        active_b[i] <= shadow_default(i);
      end
      for (int i = 0; i < MISC_N; i++) begin
        misc[i] <= RST_ZERO;
      end
      channel_select <= RST_CHANNEL_SELECT[1:0];
      lsb_first <= RST_PORT_CFG[PC_LSB_HI]; // RULE18
    end else if (soft_reset) begin
      for (int i = 0; i < SHADOW_N; i++) begin
        shadow_a[i] <= shadow_default(i); // RULE9
        shadow_b[i] <= shadow_default(i);
        active_a[i] <= shadow_default(i);
        active_b[i] <= shadow_default(i);
      end
      for (int i = 0; i < MISC_N; i++) begin
        misc[i] <= RST_ZERO;
      end
      channel_select <= RST_CHANNEL_SELECT[1:0];
      lsb_first <= RST_PORT_CFG[PC_LSB_HI];
    end else begin
      if (wr_a) begin
        shadow_a[wr_sidx] <= data_in; // RULE10
      end
      if (wr_b) begin
        shadow_b[wr_sidx] <= data_in; // RULE13
      end
      if (do_commit) begin
        // commit bit is never stored, so it reads back clear
        active_a <= shadow_a; // RULE11
        active_b <= shadow_b; // RULE11
      end
      if (wr_now && is_misc(cur_addr)) begin
        misc[misc_idx(cur_addr)] <= data_in; // RULE5
      end
      if (wr_now && (cur_addr == A_CHANNEL_SELECT)) begin
        channel_select <= data_in[1:0]; // RULE12
      end
      if (wr_now && (cur_addr == A_PORT_CFG)) begin
        lsb_first <= data_in[PC_LSB_HI] | data_in[PC_LSB_LO]; // RULE18
      end
    end
  end

  // ----------------------------------------------------------------
  // strap fallback and control outputs
  // ----------------------------------------------------------------
  wire logic [1:0] power_mode = active_a[IDX_POWER_MODES][1:0];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_mode <= 1'b1;
      STRAP_MODE <= 1'b1;
      DUTY_CYCLE_STABILIZER <= 1'b1;
      OUTPUT_FORMAT_SELECT <= 1'b0;
      OUTPUT_ENABLE_N <= 1'b0;
      POWER_DOWN <= 1'b0;
      REFERENCE_SELECT <= RST_REFERENCE_SELECT;
    end else begin
      // a select held high since reset means the port is unused
      strap_mode <= strap_mode & cs_n_s; // RULE1
      STRAP_MODE <= strap_mode & cs_n_s;
      if (strap_mode && cs_n_s) begin
        DUTY_CYCLE_STABILIZER <= sdio_s; // RULE2
        OUTPUT_FORMAT_SELECT <= sclk_s; // RULE2
        OUTPUT_ENABLE_N <= oe_strap_s; // RULE3
        POWER_DOWN <= pd_strap_s; // RULE4
      end else begin
        DUTY_CYCLE_STABILIZER <= active_a[IDX_GLOBAL_CLOCK][GC_STABILIZER_BIT]; // RULE10
        OUTPUT_FORMAT_SELECT <= active_a[IDX_OUTPUT_MODE][OM_TWOS_BIT];
        OUTPUT_ENABLE_N <= active_a[IDX_OUTPUT_MODE][OM_DISABLE_BIT];
        POWER_DOWN <= power_mode[0] ^ power_mode[1];
      end
      REFERENCE_SELECT <= active_a[IDX_REFERENCE_SELECT];
    end
  end
endmodule : acr_device
`default_nettype wire

// *** acr_host.sv ***
// host end: APB command registers driving one-byte serial frames
`timescale 1ns/10ps
`default_nettype none
module acr_host #(
  parameter int SCLK_HALF = acr_pkg::SCLK_HALF_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  acr_link_if.host LINK
);
  import acr_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} acr_hstate_t;

  // frame layout: [23:8] instruction, [7:0] data byte
  function automatic logic frame_bit(input logic [23:0] f, input logic [4:0] n, input logic lsb);
    int k;
    k = int'(n);
    if (k < INSTR_BITS) begin
      return lsb ? f[WORD_BITS + k] : f[FRAME_BITS - 1 - k]; // RULE16 RULE18
    end
    return lsb ? f[k - INSTR_BITS] : f[FRAME_BITS - 1 - k];
  endfunction : frame_bit

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  acr_hstate_t state;
  logic [12:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic read_mode;
  logic lsb_mode;
  logic [23:0] frame;
  logic [4:0] bit_no;
  logic [7:0] phase;
  logic io_meta;
  logic io_sync;

  wire logic busy = (state != H_IDLE);
  wire logic apb_done = PSEL & PENABLE & PREADY;
  wire logic apb_wr = apb_done & PWRITE;
  wire logic hit_ctrl = (PADDR == H_CTRL);
  wire logic hit_addr = (PADDR == H_ADDR);
  wire logic hit_wdata = (PADDR == H_WDATA);
  wire logic hit_rdata = (PADDR == H_RDATA);
  wire logic hit_status = (PADDR == H_STATUS);
  wire logic mapped = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_status;
  wire logic [31:0] rd_word = hit_ctrl ? {29'h0, lsb_mode, read_mode, busy} :
                              hit_addr ? {19'h0, addr_reg} :
                              hit_wdata ? {24'h0, wdata_reg} :
                              hit_rdata ? {24'h0, rdata_reg} :
                              hit_status ? {31'h0, busy} : 32'h0000_0000;
  // a start while a frame runs is dropped
  wire logic start_go = apb_wr & hit_ctrl & PWDATA[HC_START] & ~busy;
  // host forces the word-length bits to zero; address and data bits pass through unchecked
  wire logic [23:0] new_frame = {PWDATA[HC_READ], 2'b00, addr_reg, wdata_reg}; // RULE7 RULE8 RULE17

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= 8'h00;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      if (PSEL & PENABLE & ~PREADY) begin
        PRDATA <= rd_word;
        PSLVERR <= ~mapped;
      end
      if (apb_wr && hit_addr) begin
        addr_reg <= PWDATA[12:0];
      end
      if (apb_wr && hit_wdata) begin
        wdata_reg <= PWDATA[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // serial frame generator
  // ----------------------------------------------------------------
  wire logic phase_end = (phase == 8'(SCLK_HALF - 1));
  wire logic [4:0] next_bit = bit_no + 5'h01;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      io_meta <= 1'b1;
      io_sync <= 1'b1;
    end else begin
      io_meta <= LINK.serial_io_or_stabilizer_strap;
      io_sync <= io_meta;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= H_IDLE;
      frame <= '0;
      read_mode <= 1'b0;
      lsb_mode <= 1'b0;
      bit_no <= 5'h00;
      phase <= 8'h00;
      rdata_reg <= 8'h00;
      LINK.serial_clock_or_format_strap <= 1'b0;
      LINK.port_select_n <= 1'b1;
      LINK.host_io_out <= 1'b0;
      LINK.host_io_oe <= 1'b0;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (start_go) begin
            state <= H_SHIFT;
            frame <= new_frame;
            read_mode <= PWDATA[HC_READ];
            lsb_mode <= PWDATA[HC_LSB];
            bit_no <= 5'h00;
            phase <= 8'h00;
            LINK.port_select_n <= 1'b0;
            LINK.host_io_out <= frame_bit(new_frame, 5'h00, PWDATA[HC_LSB]);
            LINK.host_io_oe <= 1'b1;
          end
        end
        H_SHIFT: begin
          phase <= phase_end ? 8'h00 : phase + 8'h01;
          if (phase_end && !LINK.serial_clock_or_format_strap) begin
            LINK.serial_clock_or_format_strap <= 1'b1;
            if (read_mode && (bit_no >= 5'(INSTR_BITS))) begin
              rdata_reg <= lsb_mode ? {io_sync, rdata_reg[7:1]} : {rdata_reg[6:0], io_sync}; // RULE18
            end
          end else if (phase_end) begin
            LINK.serial_clock_or_format_strap <= 1'b0;
            if (bit_no == 5'(FRAME_BITS - 1)) begin
              state <= H_GAP;
              LINK.host_io_oe <= 1'b0;
            end else begin
              bit_no <= next_bit;
              LINK.host_io_out <= frame_bit(frame, next_bit, lsb_mode);
              // release the pin before the device starts driving data
              LINK.host_io_oe <= !(read_mode && (next_bit >= 5'(INSTR_BITS))); // RULE17
            end
          end
        end
        H_GAP: begin
          phase <= phase_end ? 8'h00 : phase + 8'h01;
          if (phase_end && !LINK.port_select_n) begin
            LINK.port_select_n <= 1'b1;
          end else if (phase_end) begin
            state <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : acr_host
`default_nettype wire

// *** acr_link_checker.sv ***
// assertions on the serial link joining host and device ends
`timescale 1ns/10ps
`default_nettype none
module acr_link_checker (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic serial_clock_or_format_strap,
  input wire logic port_select_n,
  input wire logic host_io_out,
  input wire logic host_io_oe,
  input wire logic dev_io_oe
);
  // ----------------------------------------
  // frame bit counter and link properties
  // ----------------------------------------
  logic [5:0] rises;
  wire logic sclk = serial_clock_or_format_strap;
  wire logic sel_n = port_select_n;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) rises <= 6'h00;
    else if (sel_n) rises <= 6'h00;
    else if ($rose(sclk)) rises <= rises + 6'h01;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  frame_len_a: assert property ($rose(sel_n) |-> rises == 6'd24)
    else $error("frame not 24 clock rises");
  no_clash_a: assert property (!(dev_io_oe && host_io_oe))
    else $error("both ends drive the data pin");
  dev_release_a: assert property ($rose(sel_n) |-> ##[0:8] !dev_io_oe)
    else $error("device kept the pin after frame");
  host_oe_a: assert property (host_io_oe |-> !sel_n)
    else $error("host drives pin outside frame");
  sclk_idle_a: assert property (sel_n |-> !sclk)
    else $error("serial clock moves outside frame");
  sclk_high_a: assert property ($rose(sclk) |=> sclk [*6])
    else $error("serial clock high phase too short");
  data_steady_a: assert property ($changed(host_io_out) |-> !sclk)
    else $error("host data changed with clock high");
  turnaround_a: assert property ($rose(dev_io_oe) |-> !host_io_oe && rises == 6'd16)
    else $error("device turned pin at wrong bit");
  cover property ($rose(dev_io_oe));
  cover property ($rose(sel_n) && rises == 6'd24);
  cover property ($fell(sel_n));
endmodule : acr_link_checker
`default_nettype wire

// *** tb_adc_config_register_map.sv ***
// self-checking bench joining host and device ends
`timescale 1ns/10ps
`default_nettype none
module tb_adc_config_register_map;
  import acr_pkg::*;
  // ----------------------------------------
  // harness, bus tasks and scenarios
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, lerr, oe_strap = 1'b0, pd_strap = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, last;
  logic pready, pslverr, duty_cycle_stabilizer, fmt, oe_n, pdwn, strap;
  logic [7:0] vref;
  logic lsb_on = 1'b0;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  acr_link_if link ();
  acr_host u_acr_host (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link.host));
  acr_device u_acr_device (.REF_CLK(clk), .RST_N(rst_n), .LINK(link.device),
    .MONITOR_OUT_OR_OUTPUT_ENABLE_STRAP(oe_strap), .MONITOR_CLOCK_OR_POWERDOWN_STRAP(pd_strap),
    .DUTY_CYCLE_STABILIZER(duty_cycle_stabilizer), .OUTPUT_FORMAT_SELECT(fmt), .OUTPUT_ENABLE_N(oe_n),
    .POWER_DOWN(pdwn), .STRAP_MODE(strap), .REFERENCE_SELECT(vref));
  acr_link_checker u_acr_link_checker (.REF_CLK(clk), .RST_N(rst_n),
    .serial_clock_or_format_strap(link.serial_clock_or_format_strap), .port_select_n(link.port_select_n),
    .host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe), .dev_io_oe(link.dev_io_oe));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // a frame is ~600 cycles; some thirty frames fit well inside this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    last = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic ser(input logic rd, input logic [12:0] a, input logic [7:0] d);
    apb(1'b1, H_ADDR, {19'h0, a});
    apb(1'b1, H_WDATA, {24'h0, d});
    apb(1'b1, H_CTRL, {29'h0, lsb_on, rd, 1'b1});
    do apb(1'b0, H_STATUS, 32'h0000_0000); while (last[0] !== 1'b0);
    apb(1'b0, H_RDATA, 32'h0000_0000);
  endtask : ser
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    ser(1'b1, a, 8'h00);
    chk(last[7:0], e);
  endtask : rdc
  task automatic t_straps;
    chk(vref, RST_REFERENCE_SELECT);
    chk({5'h0, strap, duty_cycle_stabilizer, fmt}, 8'h06);
    oe_strap <= 1'b1;
    pd_strap <= 1'b1;
    repeat (4) @(posedge clk);
    chk({6'h0, oe_n, pdwn}, 8'h03);
  endtask : t_straps
  task automatic t_map;
    rdc(A_PORT_CFG, RST_PORT_CFG);
    chk({7'h0, strap}, 8'h00);
    rdc(A_CHANNEL_SELECT, RST_CHANNEL_SELECT);
    rdc(A_CHIP_ID, CHIP_ID_DEFAULT);
    rdc(A_GLOBAL_CLOCK, RST_GLOBAL_CLOCK);
    ser(1'b0, A_FEAT_LAST, 8'h5C);
    rdc(A_FEAT_LAST, 8'h5C);
    rdc(13'h0030, 8'h00);
    apb(1'b0, 32'h0000_0040, 32'h0000_0000);
    chk({7'h0, lerr}, 8'h01);
  endtask : t_map
  task automatic t_shadow;
    ser(1'b0, A_REFERENCE_SELECT, 8'h80);
    chk(vref, 8'hC0);
    rdc(A_REFERENCE_SELECT, 8'h80);
    ser(1'b0, A_SHADOW_COMMIT, 8'h01);
    chk(vref, 8'h80);
    rdc(A_SHADOW_COMMIT, 8'h00);
  endtask : t_shadow
  task automatic t_local;
    ser(1'b0, A_CHANNEL_SELECT, 8'h01);
    ser(1'b0, A_OFFSET_ADJ, 8'h11);
    ser(1'b0, A_CHANNEL_SELECT, 8'h02);
    ser(1'b0, A_OFFSET_ADJ, 8'h22);
    rdc(A_OFFSET_ADJ, 8'h22);
    ser(1'b0, A_CHANNEL_SELECT, 8'h03);
    rdc(A_OFFSET_ADJ, 8'h11);
    ser(1'b0, A_OFFSET_ADJ, 8'h33);
    ser(1'b0, A_CHANNEL_SELECT, 8'h02);
    ser(1'b0, A_GLOBAL_CLOCK, 8'h00);
    rdc(A_OFFSET_ADJ, 8'h33);
    rdc(A_GLOBAL_CLOCK, 8'h00);
    ser(1'b0, A_SHADOW_COMMIT, 8'h01);
    chk({7'h0, duty_cycle_stabilizer}, 8'h00);
  endtask : t_local
  // lsb-first framing, then a soft reset sent in that order restores defaults
  task automatic t_order;
    ser(1'b0, A_PORT_CFG, 8'h42);
    lsb_on = 1'b1;
    rdc(A_PORT_CFG, 8'h5A);
    ser(1'b0, A_PORT_CFG, 8'h24);
    lsb_on = 1'b0;
    rdc(A_GLOBAL_CLOCK, RST_GLOBAL_CLOCK);
    chk(vref, RST_REFERENCE_SELECT);
    chk({7'h0, duty_cycle_stabilizer}, 8'h01);
  endtask : t_order
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_straps();
    t_map();
    t_shadow();
    t_local();
    t_order();
    conclude();
  end
endmodule : tb_adc_config_register_map
`default_nettype wire
